// ---- hcpc_config_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1 - on reset release the auto-mode strap level is caught into auto_charging_disable.
// R2 - auto mode is applied only to charging-enabled ports with upstream disconnected.
// R3 - with auto_charging_disable at 0 those ports run automatic charging mode.
// R4 - with auto_charging_disable at 1 those ports run only dedicated charging mode.
// R5 - with upstream connected every charging-enabled port runs charging-downstream mode.
// R6 - high_current_divider_enable mirrors its stored value only while unlock is 1, else the otp copy.
// R7 - on reset release the polarity strap is caught into power_switch_polarity.
module hcpc_config_reg
  import hcpc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       autoChargingStrapPin,
  input  wire logic       powerPolarityStrapPin,
  input  wire logic       otpHighCurrentDivider,
  input  wire logic       upstreamConnected,
  input  wire logic [3:0] portChargingEnable,
  input  wire logic       cfgWrite,
  input  wire logic [7:0] cfgAddr,
  input  wire logic [7:0] cfgWdata,
  output var  logic [7:0] cfgRdata,
  output var  logic [3:0] portAutoMode,
  output var  logic [3:0] portDcpMode,
  output var  logic [3:0] portCdpMode,
  output var  logic [3:0] portDividerHigh,
  output var  logic       powerSwitchPolarity
);
  logic       autoStrapSync;
  logic       polStrapSync;
  logic       otpSync;
  logic       upSync;
  logic       inReset_reg;
  logic       unlock_reg;
  logic       polarity_reg;
  logic       hiCur_reg;
  logic [1:0] rsvd_reg;
  logic       autoDis_reg;
  logic       unlock_next;
  logic       polarity_next;
  logic       hiCur_next;
  logic [1:0] rsvd_next;
  logic       autoDis_next;
  wire        cfgSel;
  wire        cfgHit;
  wire  [7:0] regValue;
  wire  [7:0] rdValue;
  wire        hiCurEff;
  wire  [3:0] autoMask;
  wire  [3:0] dcpMask;
  wire  [3:0] cdpMask;
  wire  [3:0] divMask;
  hcpc_mode_type mode;

  // address decode shared by read and write paths
  function automatic logic addr_match(input logic [7:0] addr);
    return addr == HCPC_CFG_OFFSET;
  endfunction

  // enabled ports that sit in the wanted mode
  function automatic logic [3:0] port_mask
  (
    input hcpc_mode_type cur,
    input hcpc_mode_type want,
    input logic [3:0]    enable
  );
    return (cur == want) ? enable : 4'h0;
  endfunction

  // upstream link wins, then the disable bit
  function automatic hcpc_mode_type pick_mode
  (
    input logic upLink,
    input logic autoOff
  );
    if (upLink)
      return HCPC_MODE_CDP; // see R5
    else if (autoOff)
      return HCPC_MODE_DCP; // see R4
    else
      return HCPC_MODE_AUTO; // see R3
  endfunction

  // byte image, reserved ends tied low
  function automatic logic [7:0] pack_cfg
  (
    input logic       unlock,
    input logic       polarity,
    input logic       hiCur,
    input logic [1:0] rsvd,
    input logic       autoDis
  );
    logic [7:0] img;
    img                    = 8'h00;
    img[HCPC_POS_UNLOCK]   = unlock;
    img[HCPC_POS_POLARITY] = polarity;
    img[HCPC_POS_HICUR]    = hiCur;
    img[HCPC_POS_RSVD_HI:HCPC_POS_RSVD_LO] = rsvd;
    img[HCPC_POS_AUTO_DIS] = autoDis;
    return img;
  endfunction

  hcpc_sync uAutoSync
  (
    .ref_clk (ref_clk),
    .asyncIn (autoChargingStrapPin),
    .syncOut (autoStrapSync)
  );

  hcpc_sync uPolSync
  (
    .ref_clk (ref_clk),
    .asyncIn (powerPolarityStrapPin),
    .syncOut (polStrapSync)
  );

  hcpc_sync uOtpSync
  (
    .ref_clk (ref_clk),
    .asyncIn (otpHighCurrentDivider),
    .syncOut (otpSync)
  );

  hcpc_sync uUpSync
  (
    .ref_clk (ref_clk),
    .asyncIn (upstreamConnected),
    .syncOut (upSync)
  );

  assign cfgSel   = addr_match(cfgAddr);
  assign cfgHit   = cfgWrite && cfgSel;
  // locked divider bit follows otp copy
  assign hiCurEff = unlock_reg ? hiCur_reg : otpSync; // see R6
  assign regValue = pack_cfg(unlock_reg, polarity_reg, hiCurEff,
                             rsvd_reg, autoDis_reg);
  assign rdValue  = cfgSel ? regValue : 8'h00;

  // only charging-enabled ports get any mode
  assign mode     = pick_mode(upSync, autoDis_reg);
  assign autoMask = port_mask(mode, HCPC_MODE_AUTO,
                              portChargingEnable); // see R2
  assign dcpMask  = port_mask(mode, HCPC_MODE_DCP,
                              portChargingEnable); // see R4
  assign cdpMask  = port_mask(mode, HCPC_MODE_CDP,
                              portChargingEnable); // see R5
  assign divMask  = hiCurEff ? autoMask : 4'h0; // see R6

  // strap capture on first cycle after reset, else register writes
  always_comb
  begin
    unlock_next   = unlock_reg;
    polarity_next = polarity_reg;
    hiCur_next    = hiCur_reg;
    rsvd_next     = rsvd_reg;
    autoDis_next  = autoDis_reg;
    if (inReset_reg)
    begin
      autoDis_next  = autoStrapSync; // see R1
      polarity_next = polStrapSync;  // see R7
    end
    else if (cfgHit)
    begin
      unlock_next   = cfgWdata[HCPC_POS_UNLOCK];
      polarity_next = cfgWdata[HCPC_POS_POLARITY]; // see R7
      rsvd_next     = cfgWdata[HCPC_POS_RSVD_HI:HCPC_POS_RSVD_LO];
      autoDis_next  = cfgWdata[HCPC_POS_AUTO_DIS];
      if (unlock_reg)
      begin
        hiCur_next = cfgWdata[HCPC_POS_HICUR]; // see R6
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      inReset_reg  <= 1'b1;
      unlock_reg   <= HCPC_UNLOCK_RESET;
      polarity_reg <= HCPC_POL_RESET;
      hiCur_reg    <= HCPC_HICUR_RESET;
      rsvd_reg     <= HCPC_RSVD_RESET;
      autoDis_reg  <= HCPC_AUTO_RESET;
    end
    else
    begin
      inReset_reg  <= 1'b0;
      unlock_reg   <= unlock_next;
      polarity_reg <= polarity_next;
      hiCur_reg    <= hiCur_next;
      rsvd_reg     <= rsvd_next;
      autoDis_reg  <= autoDis_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfgRdata            <= 8'h00;
      portAutoMode        <= 4'h0;
      portDcpMode         <= 4'h0;
      portCdpMode         <= 4'h0;
      portDividerHigh     <= 4'h0;
      powerSwitchPolarity <= 1'b0;
    end
    else
    begin
      cfgRdata            <= rdValue;
      portAutoMode        <= autoMask; // see R2
      portDcpMode         <= dcpMask;  // see R4
      portCdpMode         <= cdpMask;  // see R5
      portDividerHigh     <= divMask;  // see R6
      powerSwitchPolarity <= polarity_reg;
    end
  end
endmodule // hcpc_config_reg
`default_nettype wire

// ---- hcpc_config_reg_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module hcpc_config_reg_asserts
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       autoChargingStrapPin,
  input wire logic       powerPolarityStrapPin,
  input wire logic [3:0] portChargingEnable,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgRdata,
  input wire logic [3:0] portAutoMode,
  input wire logic [3:0] portDcpMode,
  input wire logic [3:0] portCdpMode,
  input wire logic [3:0] portDividerHigh,
  input wire logic       powerSwitchPolarity
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_auto_strap: assert property ($fell(rst) && cfgAddr == 8'h0A
    |-> ##[2:4] cfgRdata[1] == autoChargingStrapPin) else $error("strap");
  a_auto_gated: assert property (
    (portAutoMode & ~$past(portChargingEnable)) == 4'h0) else $error("gate");
  a_auto_dcp_excl: assert property (
    (portAutoMode & portDcpMode) == 4'h0) else $error("auto dcp");
  a_cdp_excl: assert property (
    (portCdpMode & (portAutoMode | portDcpMode)) == 4'h0) else $error("cdp");
  a_div_auto: assert property (
    (portDividerHigh & ~portAutoMode) == 4'h0) else $error("divider");
  a_rsvd_zero: assert property (
    cfgRdata[7] == 1'b0 && cfgRdata[0] == 1'b0) else $error("reserved");
  a_pol_strap: assert property ($fell(rst)
    |-> ##[1:3] powerSwitchPolarity == powerPolarityStrapPin) else $error("pol");
  cover property (portAutoMode != 4'h0);
  cover property (portDcpMode != 4'h0);
  cover property (portCdpMode != 4'h0);
endmodule // hcpc_config_reg_asserts
`default_nettype wire

// ---- hcpc_config_reg_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module hcpc_config_reg_test;
  import hcpc_pkg::*;
  logic       ref_clk = 1'b0, rst = 1'b1, aStrap = 1'b1, pStrap = 1'b1;
  logic       otp = 1'b1, upConn = 1'b1, cfgWrite, pol;
  logic [3:0] chgEn = 4'h5, auto, dcp, cdp, divHi;
  logic [7:0] cfgAddr, cfgWdata, cfgRdata;
  int         err_count = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  hcpc_host_model host(.ref_clk(ref_clk), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata));
  hcpc_config_reg uut(.ref_clk(ref_clk), .rst(rst),
    .autoChargingStrapPin(aStrap), .powerPolarityStrapPin(pStrap),
    .otpHighCurrentDivider(otp), .upstreamConnected(upConn),
    .portChargingEnable(chgEn), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .portAutoMode(auto),
    .portDcpMode(dcp), .portCdpMode(cdp), .portDividerHigh(divHi),
    .powerSwitchPolarity(pol));
  task automatic chk(input string n, input logic [7:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] e);
    repeat (5) @(negedge ref_clk);
    chk("cfgRdata", e, cfgRdata);
  endtask
  task automatic t_reset;
    rd(8'h32);
    chk("polarity", 8'h01, {7'h0, pol});
    chk("cdp", 8'h05, {4'h0, cdp});
  endtask
  task automatic t_lock;
    otp = 1'b0;
    host.wr(8'h92);
    rd(8'h02);
    host.wr(8'h40);
    host.wr(8'h51);
    rd(8'h50);
    host.cfgAddr = 8'h0B;
    rd(8'h00);
    host.cfgAddr = 8'h0A;
  endtask
  task automatic t_modes;
    upConn = 1'b0;
    host.wr(8'h52);
    rd(8'h52);
    chk("dcp", 8'h05, {4'h0, dcp});
    host.wr(8'h50);
    rd(8'h50);
    chk("auto", 8'h05, {4'h0, auto});
    chk("divHi", 8'h05, {4'h0, divHi});
  endtask
  task automatic t_rereset;
    aStrap = 1'b1;
    pStrap = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rd(8'h02);
    chk("polarity", 8'h00, {7'h0, pol});
    chk("dcp", 8'h05, {4'h0, dcp});
    chk("divHi", 8'h00, {4'h0, divHi});
  endtask
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_lock;
    t_modes;
    t_rereset;
    tally_and_finish;
  end
  initial
  begin
    #20000;
    err_count++;
    tally_and_finish;
  end
endmodule // hcpc_config_reg_test
bind hcpc_config_reg hcpc_config_reg_asserts chkr(.*);
`default_nettype wire

// ---- hcpc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module hcpc_host_model
(
  input  wire logic       ref_clk,
  output var  logic       cfgWrite,
  output var  logic [7:0] cfgAddr,
  output var  logic [7:0] cfgWdata
);
  initial {cfgWrite, cfgAddr, cfgWdata} = {1'b0, 8'h0A, 8'h00};
  // one-cycle write strobe, data scrambled once released
  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk);
    cfgWrite = 1'b1;
    cfgWdata = d;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
    cfgWdata = ~d;
  endtask
endmodule // hcpc_host_model
`default_nettype wire

// ---- hcpc_pkg.sv ----
package hcpc_pkg;
  localparam logic [7:0] HCPC_CFG_OFFSET     = 8'h0A;
  localparam int         HCPC_POS_UNLOCK     = 6;
  localparam int         HCPC_POS_POLARITY   = 5;
  localparam int         HCPC_POS_HICUR      = 4;
  localparam int         HCPC_POS_RSVD_HI    = 3;
  localparam int         HCPC_POS_RSVD_LO    = 2;
  localparam int         HCPC_POS_AUTO_DIS   = 1;
  localparam logic       HCPC_UNLOCK_RESET   = 1'b0;
  localparam logic [1:0] HCPC_RSVD_RESET     = 2'h0;
  localparam logic       HCPC_HICUR_RESET    = 1'b0;
  localparam logic       HCPC_AUTO_RESET     = 1'b0;
  localparam logic       HCPC_POL_RESET      = 1'b0;

  typedef enum logic [1:0] {
    HCPC_MODE_NONE,
    HCPC_MODE_CDP,
    HCPC_MODE_DCP,
    HCPC_MODE_AUTO
  } hcpc_mode_type;
endpackage

// ---- hcpc_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module hcpc_sync
  import hcpc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic asyncIn,
  output var  logic syncOut
);
  logic stage1_reg;

  // no reset: straps must settle while rst is still held
  always_ff @(posedge ref_clk)
  begin
    stage1_reg <= asyncIn;
    syncOut    <= stage1_reg;
  end
endmodule // hcpc_sync
`default_nettype wire
